// ---- hw/tsr_link.sv ----
// link-clock end of the register access handshake
`timescale 1ns/1ps
module tsr_link (
  input  wire logic       link_clk_i,
  input  wire logic       resetn_i,
  input  wire logic       lnk_cmd_valid_i,
  input  wire logic [1:0] lnk_cmd_i,
  input  wire logic [7:0] lnk_wdata_i,
  output logic            lnk_busy_o,
  output logic            lnk_rvalid_o,
  output logic [7:0]      lnk_rdata_o,
  output logic            req_tgl_o,
  output logic [1:0]      req_cmd_o,
  output logic [7:0]      req_wdata_o,
  input  wire logic       ack_tgl_i,
  input  wire logic [7:0] ack_rdata_i
);

  logic ack_s1_ff;
  logic ack_s2_ff;
  logic ack_s3_ff;

  wire take     = lnk_cmd_valid_i & ~lnk_busy_o;
  wire ack_edge = ack_s2_ff ^ ack_s3_ff;
  wire was_rd   = (req_cmd_o == tsr_pkg::CMD_RD);

  // cmd and data stay put until the ack returns, so the core may sample them
  always_ff @(posedge link_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ack_s1_ff    <= 1'b0;
      ack_s2_ff    <= 1'b0;
      ack_s3_ff    <= 1'b0;
      req_tgl_o    <= 1'b0;
      req_cmd_o    <= 2'h0;
      req_wdata_o  <= 8'h00;
      lnk_busy_o   <= 1'b0;
      lnk_rvalid_o <= 1'b0;
      lnk_rdata_o  <= 8'h00;
    end else begin
      ack_s1_ff    <= ack_tgl_i;
      ack_s2_ff    <= ack_s1_ff;
      ack_s3_ff    <= ack_s2_ff;
      lnk_busy_o   <= take | (lnk_busy_o & ~ack_edge);
      lnk_rvalid_o <= ack_edge & was_rd;
      if (take) begin
        req_tgl_o   <= ~req_tgl_o;
        req_cmd_o   <= lnk_cmd_i;
        req_wdata_o <= lnk_wdata_i;
      end
      if (ack_edge) begin
        lnk_rdata_o <= ack_rdata_i;
      end
    end
  end

endmodule // tsr_link

// ---- hw/tsr_pkg.sv ----
// shared constants and types of the temperature sensor register block
package tsr_pkg;

  // ************************************************************
  // register select and link commands
  // ************************************************************
  localparam logic [1:0] IDX_RESULT = 2'h0;
  localparam logic [1:0] IDX_CFG    = 2'h1;
  localparam logic [1:0] IDX_LOW    = 2'h2;
  localparam logic [1:0] IDX_HIGH   = 2'h3;
  localparam logic [7:0] PTR_RST    = 8'h00;

  localparam logic [1:0] CMD_PTR    = 2'h0;
  localparam logic [1:0] CMD_START  = 2'h1;
  localparam logic [1:0] CMD_WR     = 2'h2;
  localparam logic [1:0] CMD_RD     = 2'h3;

  // ************************************************************
  // control_settings field positions and reset values
  // ************************************************************
  localparam int B1_OS  = 7;
  localparam int B1_FQH = 4;
  localparam int B1_FQL = 3;
  localparam int B1_POL = 2;
  localparam int B1_TM  = 1;
  localparam int B1_SD  = 0;
  localparam int B2_CRH = 7;
  localparam int B2_CRL = 6;
  localparam int B2_EM  = 4;

  localparam logic [1:0] RES_FIELD = 2'h3;
  localparam logic [1:0] FQ_RST    = 2'h0;
  localparam logic [1:0] CR_RST    = 2'h2;
  localparam logic       POL_RST   = 1'b0;
  localparam logic       TM_RST    = 1'b0;
  localparam logic       SD_RST    = 1'b0;
  localparam logic       EM_RST    = 1'b0;
  localparam logic       OS_RST    = 1'b0;
  localparam logic [15:0] HIGH_RST = 16'h5000;
  localparam logic [15:0] LOW_RST  = 16'h4b00;

  // ************************************************************
  // fault queue depths and conversion pacing
  // ************************************************************
  localparam logic [2:0] FQ_N0 = 3'h1;
  localparam logic [2:0] FQ_N1 = 3'h2;
  localparam logic [2:0] FQ_N2 = 3'h4;
  localparam logic [2:0] FQ_N3 = 3'h6;

  localparam int unsigned CLK_KHZ  = 200000;
  localparam int unsigned PER_MS_0 = 4000;
  localparam int unsigned PER_MS_1 = 1000;
  localparam int unsigned PER_MS_2 = 250;
  localparam int unsigned PER_MS_3 = 125;
  localparam int unsigned PER_CYC_0 = PER_MS_0 * CLK_KHZ;
  localparam int unsigned PER_CYC_1 = PER_MS_1 * CLK_KHZ;
  localparam int unsigned PER_CYC_2 = PER_MS_2 * CLK_KHZ;
  localparam int unsigned PER_CYC_3 = PER_MS_3 * CLK_KHZ;

  typedef enum logic [1:0] {
    ST_BOOT = 2'b00,
    ST_RUN  = 2'b01,
    ST_WAIT = 2'b10,
    ST_OFF  = 2'b11
  } tsr_state_t;

endpackage

// ---- hw/tsr_top.sv ----
// temperature sensor registers, conversion pacing and thermostat alert
`timescale 1ns/1ps
module tsr_top #(
  parameter int unsigned PER_CYC_0 = tsr_pkg::PER_CYC_0,
  parameter int unsigned PER_CYC_1 = tsr_pkg::PER_CYC_1,
  parameter int unsigned PER_CYC_2 = tsr_pkg::PER_CYC_2,
  parameter int unsigned PER_CYC_3 = tsr_pkg::PER_CYC_3
) (
  input  wire logic        core_clk_i,
  input  wire logic        resetn_i,
  input  wire logic        link_clk_i,
  input  wire logic        lnk_cmd_valid_i,
  input  wire logic [1:0]  lnk_cmd_i,
  input  wire logic [7:0]  lnk_wdata_i,
  output logic             lnk_busy_o,
  output logic             lnk_rvalid_o,
  output logic [7:0]       lnk_rdata_o,
  output logic             conv_start_o,
  input  wire logic        conv_done_i,
  input  wire logic [12:0] conv_data_i,
  output logic             alert_o
);

  // ************************************************************
  // declarations
  // ************************************************************
  logic                rq_s1_ff;
  logic                rq_s2_ff;
  logic                rq_s3_ff;
  logic                ack_ff;
  logic [7:0]          rdata_ff;
  logic [7:0]          ptr_ff;
  logic [1:0]          idx_ff;
  logic [1:0]          nxt_idx;
  logic                os_done_ff;
  logic                os_req_ff;
  logic                oneshot_ff;
  logic [1:0]          fq_ff;
  logic [1:0]          cr_ff;
  logic                pol_ff;
  logic                tm_ff;
  logic                sd_ff;
  logic                em_ff;
  logic [15:0]         hi_ff;
  logic [15:0]         lo_ff;
  logic [12:0]         res_ff;
  logic                comp_ff;
  logic                int_ff;
  logic [2:0]          fcnt_ff;
  logic [31:0]         tmr_ff;
  tsr_pkg::tsr_state_t st_ff;
  tsr_pkg::tsr_state_t nxt_st;
  logic                go;
  wire                 lk_tgl;
  wire  [1:0]          lk_cmd;
  wire  [7:0]          lk_wd;

  // ************************************************************
  // link side and crossing
  // ************************************************************
  tsr_link u_link (
    .link_clk_i      (link_clk_i),
    .resetn_i        (resetn_i),
    .lnk_cmd_valid_i (lnk_cmd_valid_i),
    .lnk_cmd_i       (lnk_cmd_i),
    .lnk_wdata_i     (lnk_wdata_i),
    .lnk_busy_o      (lnk_busy_o),
    .lnk_rvalid_o    (lnk_rvalid_o),
    .lnk_rdata_o     (lnk_rdata_o),
    .req_tgl_o       (lk_tgl),
    .req_cmd_o       (lk_cmd),
    .req_wdata_o     (lk_wd),
    .ack_tgl_i       (ack_ff),
    .ack_rdata_i     (rdata_ff)
  );

  wire req_ev   = rq_s2_ff ^ rq_s3_ff;
  wire do_ptr   = req_ev & (lk_cmd == tsr_pkg::CMD_PTR);
  wire do_start = req_ev & (lk_cmd == tsr_pkg::CMD_START);
  wire do_wr    = req_ev & (lk_cmd == tsr_pkg::CMD_WR);
  wire do_rd    = req_ev & (lk_cmd == tsr_pkg::CMD_RD);

  // ************************************************************
  // register decode
  // ************************************************************
  // upper index bits are kept but never decoded
  wire [1:0] sel    = ptr_ff[1:0];
  wire       wr_msb = do_wr & (idx_ff == 2'h0);
  wire       wr_lsb = do_wr & (idx_ff == 2'h1);
  wire       w_cfg  = sel == tsr_pkg::IDX_CFG;
  wire       w_lo   = sel == tsr_pkg::IDX_LOW;
  wire       w_hi   = sel == tsr_pkg::IDX_HIGH;
  wire       cfg_w1 = wr_msb & w_cfg;
  wire       cfg_w2 = wr_lsb & w_cfg;
  wire       nxt_sd = cfg_w1 ? lk_wd[tsr_pkg::B1_SD] : sd_ff;
  wire       sd_rise = nxt_sd & ~sd_ff;
  // trigger counts only together with power-down set in the same byte
  wire       os_go  = cfg_w1 & lk_wd[tsr_pkg::B1_OS] & nxt_sd;

  // ************************************************************
  // read data
  // ************************************************************
  wire [15:0] res_word = em_ff ? {res_ff, 3'h1}
                               : {res_ff[11:0], 4'h0};
  wire        al_rd    = ~(comp_ff ^ pol_ff);
  wire [15:0] cfg_word = {os_done_ff, tsr_pkg::RES_FIELD, fq_ff, pol_ff,
                          tm_ff, sd_ff, cr_ff, al_rd, em_ff, 4'h0};
  wire [15:0] thr_mask = em_ff ? 16'hfff8 : 16'hfff0;
  wire [15:0] rd_word  = (sel == tsr_pkg::IDX_RESULT) ? res_word :
                         w_cfg ? cfg_word :
                         w_lo  ? (lo_ff & thr_mask) :
                                 (hi_ff & thr_mask);
  wire [7:0]  rd_byte  = (idx_ff == 2'h0) ? rd_word[15:8] : rd_word[7:0];

  // a new start or index write restarts the byte count, so a short read is harmless
  always_comb begin
    nxt_idx = idx_ff;
    if (do_ptr | do_start) begin
      nxt_idx = 2'h0;
    end else if ((do_wr | do_rd) & (idx_ff != 2'h2)) begin
      nxt_idx = idx_ff + 2'h1;
    end
  end

  // ************************************************************
  // thermostat compare and fault queue
  // ************************************************************
  wire               done    = conv_done_i & (st_ff == tsr_pkg::ST_RUN);
  wire signed [12:0] cur_val = em_ff ? conv_data_i
                                     : {conv_data_i[11], conv_data_i[11:0]};
  wire signed [12:0] hi_val  = em_ff ? hi_ff[15:3] : {hi_ff[15], hi_ff[15:4]};
  wire signed [12:0] lo_val  = em_ff ? lo_ff[15:3] : {lo_ff[15], lo_ff[15:4]};
  wire               fault   = comp_ff ? (cur_val < lo_val)
                                       : (cur_val >= hi_val);
  wire [2:0]         need    = (fq_ff == 2'h0) ? tsr_pkg::FQ_N0 :
                               (fq_ff == 2'h1) ? tsr_pkg::FQ_N1 :
                               (fq_ff == 2'h2) ? tsr_pkg::FQ_N2 :
                                                 tsr_pkg::FQ_N3;
  wire [2:0]         fcnt_up = fcnt_ff + 3'h1;
  wire               trip    = done & fault & (fcnt_up >= need);
  // a read or entering power-down acknowledges; a fresh trip in that cycle wins
  wire               int_clr = do_rd | sd_rise;
  wire               act     = tm_ff ? int_ff : comp_ff;

  // ************************************************************
  // conversion pacing
  // ************************************************************
  wire [31:0] period = (cr_ff == 2'h0) ? 32'(PER_CYC_0) :
                       (cr_ff == 2'h1) ? 32'(PER_CYC_1) :
                       (cr_ff == 2'h2) ? 32'(PER_CYC_2) :
                                         32'(PER_CYC_3);
  wire        tmr_end = tmr_ff >= (period - 32'h1);

  always_comb begin
    nxt_st = st_ff;
    go     = 1'b0;
    case (st_ff)
      tsr_pkg::ST_BOOT: begin
        go     = 1'b1;
        nxt_st = tsr_pkg::ST_RUN;
      end
      tsr_pkg::ST_RUN: begin
        if (done) begin
          nxt_st = (sd_ff | oneshot_ff) ? tsr_pkg::ST_OFF : tsr_pkg::ST_WAIT;
        end
      end
      tsr_pkg::ST_WAIT: begin
        if (sd_ff) begin
          nxt_st = tsr_pkg::ST_OFF;
        end else if (tmr_end) begin
          go     = 1'b1;
          nxt_st = tsr_pkg::ST_RUN;
        end
      end
      tsr_pkg::ST_OFF: begin
        if (~sd_ff | os_req_ff) begin
          go     = 1'b1;
          nxt_st = tsr_pkg::ST_RUN;
        end
      end
      default: begin
        nxt_st = tsr_pkg::ST_BOOT;
      end
    endcase
  end

  // ************************************************************
  // handshake and register file
  // ************************************************************
  // only the toggle crosses; cmd and data settled long before it lands here
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rq_s1_ff <= 1'b0;
      rq_s2_ff <= 1'b0;
      rq_s3_ff <= 1'b0;
      ack_ff   <= 1'b0;
    end else begin
      rq_s1_ff <= lk_tgl;
      rq_s2_ff <= rq_s1_ff;
      rq_s3_ff <= rq_s2_ff;
      if (req_ev) begin
        ack_ff <= ~ack_ff;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_ff <= 8'h00;
      ptr_ff   <= tsr_pkg::PTR_RST;
      idx_ff   <= 2'h0;
    end else begin
      idx_ff   <= nxt_idx;
      if (do_rd) begin
        rdata_ff <= rd_byte;
      end
      if (do_ptr) begin
        ptr_ff <= lk_wd;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fq_ff  <= tsr_pkg::FQ_RST;
      pol_ff <= tsr_pkg::POL_RST;
      tm_ff  <= tsr_pkg::TM_RST;
      sd_ff  <= tsr_pkg::SD_RST;
      cr_ff  <= tsr_pkg::CR_RST;
      em_ff  <= tsr_pkg::EM_RST;
    end else begin
      sd_ff <= nxt_sd;
      if (cfg_w1) begin
        fq_ff  <= lk_wd[tsr_pkg::B1_FQH:tsr_pkg::B1_FQL];
        pol_ff <= lk_wd[tsr_pkg::B1_POL];
        tm_ff  <= lk_wd[tsr_pkg::B1_TM];
      end
      if (cfg_w2) begin
        cr_ff <= lk_wd[tsr_pkg::B2_CRH:tsr_pkg::B2_CRL];
        em_ff <= lk_wd[tsr_pkg::B2_EM];
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hi_ff <= tsr_pkg::HIGH_RST;
      lo_ff <= tsr_pkg::LOW_RST;
    end else begin
      if (wr_msb & w_hi) begin
        hi_ff[15:8] <= lk_wd;
      end
      if (wr_lsb & w_hi) begin
        hi_ff[7:0] <= lk_wd;
      end
      if (wr_msb & w_lo) begin
        lo_ff[15:8] <= lk_wd;
      end
      if (wr_lsb & w_lo) begin
        lo_ff[7:0] <= lk_wd;
      end
    end
  end

  // ************************************************************
  // conversion, thermostat and alert pin
  // ************************************************************
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_ff        <= tsr_pkg::ST_BOOT;
      tmr_ff       <= 32'h0;
      conv_start_o <= 1'b0;
    end else begin
      st_ff        <= nxt_st;
      conv_start_o <= go;
      // timer saturates, so a shorter interval written late fires at once
      tmr_ff       <= go ? 32'h0 : (tmr_end ? tmr_ff : tmr_ff + 32'h1);
    end
  end

  // one-shot bookkeeping and the stored result
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      os_req_ff    <= 1'b0;
      oneshot_ff   <= 1'b0;
      os_done_ff   <= tsr_pkg::OS_RST;
      res_ff       <= 13'h0;
    end else begin
      os_req_ff    <= os_go | (os_req_ff & ~go);
      if (go) begin
        oneshot_ff <= sd_ff;
      end
      // trigger reads 0 while its conversion runs, 1 once it is done
      os_done_ff   <= (done & oneshot_ff) | (os_done_ff & ~go);
      if (done) begin
        res_ff <= conv_data_i;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      comp_ff <= 1'b0;
      int_ff  <= 1'b0;
      fcnt_ff <= 3'h0;
    end else begin
      if (trip) begin
        comp_ff <= ~comp_ff;
        fcnt_ff <= 3'h0;
      end else if (done) begin
        fcnt_ff <= fault ? fcnt_up : 3'h0;
      end
      int_ff  <= trip | (int_ff & ~int_clr);
    end
  end

  // pin from a flop, so no glitch while mode or polarity bits change
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      alert_o <= 1'b1;
    end else begin
      alert_o <= pol_ff ? act : ~act;
    end
  end

endmodule // tsr_top

// ---- test/tb_top.sv ----
// self-checking bench of the temperature sensor register block
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_fail++; \
  $display("unexpected at %0t: got %h expected %h", $time, (a), (b)); end end
module tb_top;
  logic        core_clk, link_clk, resetn, vld, busy, rvalid, conv_start, conv_done, alert;
  logic [1:0]  cmd;
  logic [7:0]  wdata, rdata;
  logic [12:0] conv_data, temp;
  logic [15:0] v;
  int          n_fail, check_count, starts, k, n0;
  int          nf[4] = '{1, 2, 4, 6};
  int          per[4] = '{400, 200, 100, 50};
  real         t0;
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  initial begin
    link_clk = 1'b0;
    #1.3;
    forever #3 link_clk = ~link_clk;
  end
  // instant converter: done one cycle after start, data scrambled otherwise
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      conv_done <= 1'b0;
      conv_data <= 13'h0000;
      starts    <= 0;
    end else begin
      conv_done <= conv_start;
      conv_data <= conv_start ? temp : ~temp;
      starts    <= starts + int'(conv_start);
    end
  end
  tsr_top #(.PER_CYC_0(400), .PER_CYC_1(200), .PER_CYC_2(100), .PER_CYC_3(50)) dut (
    .core_clk_i(core_clk), .resetn_i(resetn), .link_clk_i(link_clk), .lnk_cmd_valid_i(vld),
    .lnk_cmd_i(cmd), .lnk_wdata_i(wdata), .lnk_busy_o(busy), .lnk_rvalid_o(rvalid),
    .lnk_rdata_o(rdata), .conv_start_o(conv_start), .conv_done_i(conv_done),
    .conv_data_i(conv_data), .alert_o(alert));
  tsr_host_model h (
    .link_clk_i(link_clk), .lnk_busy_i(busy), .lnk_rvalid_i(rvalid), .lnk_rdata_i(rdata),
    .lnk_cmd_valid_o(vld), .lnk_cmd_o(cmd), .lnk_wdata_o(wdata));
  // ****************************************
  // helpers
  // ****************************************
  task automatic settle;
    repeat (6) @(negedge core_clk);
  endtask
  task automatic wait_conv(input int n);
    repeat (n) @(posedge conv_done);
    settle();
  endtask
  task automatic count_to(input logic lvl, output int c);
    c = 0;
    do begin wait_conv(1); c++; end while (alert !== lvl && c < 10);
  endtask
  task automatic finish_test;
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_regs;
    logic [7:0] b;
    h.xfer(tsr_pkg::CMD_START, 8'h00, b);
    h.xfer(tsr_pkg::CMD_RD, 8'h00, b);
    `CHK(b, temp[11:4])
    h.rd(tsr_pkg::IDX_CFG, 2, v);
    `CHK(v, 16'h60a0)
    h.wr(tsr_pkg::IDX_CFG, 8'h00, 8'ha0, 2);
    h.rd(tsr_pkg::IDX_CFG, 2, v);
    `CHK(v, 16'h60a0)
    h.rd(tsr_pkg::IDX_LOW, 2, v);
    `CHK(v, 16'h4b00)
    h.rd(tsr_pkg::IDX_HIGH, 2, v);
    `CHK(v, 16'h5000)
    h.wr(tsr_pkg::IDX_RESULT, 8'hff, 8'hff, 2);
    h.rd(tsr_pkg::IDX_RESULT, 2, v);
    `CHK(v, {temp[11:0], 4'h0})
    h.wr(tsr_pkg::IDX_LOW, 8'h12, 8'h34, 2);
    h.rd(tsr_pkg::IDX_LOW, 2, v);
    `CHK(v, 16'h1230)
    h.wr(tsr_pkg::IDX_LOW, 8'h4b, 8'h00, 1);
    h.rd(tsr_pkg::IDX_LOW, 2, v);
    `CHK(v, 16'h4b30)
  endtask
  task automatic t_fmt;
    temp = 13'h1abc;
    h.wr(tsr_pkg::IDX_CFG, 8'h60, 8'h90, 2);
    wait_conv(2);
    h.rd(tsr_pkg::IDX_RESULT, 2, v);
    `CHK(v, {temp, 3'h1})
    h.rd(tsr_pkg::IDX_RESULT, 1, v);
    `CHK(v[15:8], temp[12:5])
    h.wr(tsr_pkg::IDX_CFG, 8'h60, 8'ha0, 2);
    wait_conv(2);
    h.rd(tsr_pkg::IDX_RESULT, 2, v);
    `CHK(v, {temp[11:0], 4'h0})
  endtask
  task automatic t_fault;
    h.wr(tsr_pkg::IDX_LOW, 8'h4b, 8'h00, 2);
    for (int f = 0; f < 4; f++) begin
      temp = 13'h04af;
      h.wr(tsr_pkg::IDX_CFG, {3'h3, f[1:0], 3'h0}, 8'ha0, 2);
      count_to(1'b1, k);
      temp = 13'h0500;
      count_to(1'b0, k);
      `CHK(k, nf[f])
      h.rd(tsr_pkg::IDX_CFG, 2, v);
      `CHK(v, {3'h3, f[1:0], 3'h0, 8'h80})
      temp = 13'h04b0;
      wait_conv(1);
      `CHK(alert, 1'b0)
      temp = 13'h04af;
      count_to(1'b1, k);
      `CHK(k, nf[f])
    end
    h.wr(tsr_pkg::IDX_CFG, 8'h70, 8'ha0, 2);
    temp = 13'h0500;
    wait_conv(3);
    temp = 13'h04af;
    wait_conv(1);
    temp = 13'h0500;
    count_to(1'b0, k);
    `CHK(k, 4)
  endtask
  task automatic t_int;
    temp = 13'h04af;
    h.wr(tsr_pkg::IDX_CFG, 8'h64, 8'ha0, 2);
    count_to(1'b0, k);
    `CHK(k, 1)
    `CHK(alert, 1'b0)
    h.wr(tsr_pkg::IDX_CFG, 8'h62, 8'ha0, 2);
    h.rd(tsr_pkg::IDX_RESULT, 2, v);
    settle();
    `CHK(alert, 1'b1)
    temp = 13'h0500;
    count_to(1'b0, k);
    `CHK(k, 1)
    h.rd(tsr_pkg::IDX_RESULT, 2, v);
    settle();
    `CHK(alert, 1'b1)
    wait_conv(1);
    `CHK(alert, 1'b1)
    temp = 13'h04af;
    count_to(1'b0, k);
    `CHK(k, 1)
    h.rd(tsr_pkg::IDX_LOW, 1, v);
    settle();
    `CHK(alert, 1'b1)
    temp = 13'h0500;
    count_to(1'b0, k);
    h.wr(tsr_pkg::IDX_CFG, 8'h63, 8'ha0, 1);
    settle();
    `CHK(alert, 1'b1)
  endtask
  task automatic t_sd;
    repeat (10) @(negedge core_clk);
    n0 = starts;
    repeat (300) @(negedge core_clk);
    `CHK(starts - n0, 0)
    temp = 13'h0123;
    h.wr(tsr_pkg::IDX_CFG, 8'he3, 8'ha0, 1);
    repeat (300) @(negedge core_clk);
    `CHK(starts - n0, 1)
    h.rd(tsr_pkg::IDX_RESULT, 2, v);
    `CHK(v, {temp[11:0], 4'h0})
    h.rd(tsr_pkg::IDX_CFG, 1, v);
    `CHK(v[15:8], 8'he3)
  endtask
  task automatic t_rate;
    for (int c = 0; c < 4; c++) begin
      h.wr(tsr_pkg::IDX_CFG, 8'h60, {c[1:0], 6'h00}, 2);
      @(posedge conv_start);
      @(posedge conv_start);
      t0 = $realtime;
      @(posedge conv_start);
      `CHK(int'(($realtime - t0) / 5.0), per[c])
    end
  endtask
  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial begin
    resetn = 1'b0;
    temp = 13'h0190;
    repeat (6) @(posedge core_clk);
    resetn <= 1'b1;
    t_regs();
    t_fmt();
    t_fault();
    t_int();
    t_sd();
    t_rate();
    finish_test();
  end
  initial begin
    #400000;
    n_fail++;
    finish_test();
  end
endmodule // tb_top

// ---- test/tsr_host_model.sv ----
// link-side host model issuing register commands
`timescale 1ns/1ps
module tsr_host_model (
  input  wire logic       link_clk_i,
  input  wire logic       lnk_busy_i,
  input  wire logic       lnk_rvalid_i,
  input  wire logic [7:0] lnk_rdata_i,
  output logic            lnk_cmd_valid_o,
  output logic [1:0]      lnk_cmd_o,
  output logic [7:0]      lnk_wdata_o
);
  initial begin
    lnk_cmd_valid_o = 1'b0;
    lnk_cmd_o = 2'h0;
    lnk_wdata_o = 8'h00;
  end
  // data scrambled after the take so stale bytes never pass for good ones
  task automatic xfer(input logic [1:0] c, input logic [7:0] d, output logic [7:0] r);
    int n;
    n = 0;
    r = 8'h00;
    @(posedge link_clk_i);
    lnk_cmd_valid_o <= 1'b1;
    lnk_cmd_o <= c;
    lnk_wdata_o <= d;
    @(posedge link_clk_i);
    lnk_cmd_valid_o <= 1'b0;
    lnk_wdata_o <= ~d;
    do @(negedge link_clk_i); while (!lnk_busy_i && ++n < 4);
    do begin
      @(negedge link_clk_i);
      if (lnk_rvalid_i)
        r = lnk_rdata_i;
    end while (lnk_busy_i && ++n < 40);
  endtask
  task automatic wr(input logic [1:0] idx, input logic [7:0] b1, input logic [7:0] b2,
                    input int nb);
    logic [7:0] r;
    xfer(tsr_pkg::CMD_PTR, {6'h00, idx}, r);
    xfer(tsr_pkg::CMD_WR, b1, r);
    if (nb > 1)
      xfer(tsr_pkg::CMD_WR, b2, r);
  endtask
  task automatic rd(input logic [1:0] idx, input int nb, output logic [15:0] v);
    logic [7:0] a;
    logic [7:0] b;
    xfer(tsr_pkg::CMD_PTR, {6'h00, idx}, a);
    xfer(tsr_pkg::CMD_RD, 8'h00, a);
    b = 8'h00;
    if (nb > 1)
      xfer(tsr_pkg::CMD_RD, 8'h00, b);
    v = {a, b};
  endtask
endmodule // tsr_host_model

// ---- test/tsr_top_asserts.sv ----
// assertion checker of the temperature sensor register block
`timescale 1ns/1ps
module tsr_top_asserts (
  input wire logic        core_clk_i,
  input wire logic        resetn_i,
  input wire logic        link_clk_i,
  input wire logic        lnk_cmd_valid_i,
  input wire logic [1:0]  lnk_cmd_i,
  input wire logic [7:0]  lnk_wdata_i,
  input wire logic        lnk_busy_o,
  input wire logic        lnk_rvalid_o,
  input wire logic [7:0]  lnk_rdata_o,
  input wire logic        conv_start_o,
  input wire logic        conv_done_i,
  input wire logic [12:0] conv_data_i,
  input wire logic        alert_o
);
  // remembers whether the command in flight is a read
  logic rd_ff;
  always_ff @(posedge link_clk_i or negedge resetn_i) begin
    if (!resetn_i)
      rd_ff <= 1'b0;
    else if (lnk_cmd_valid_i && !lnk_busy_o)
      rd_ff <= (lnk_cmd_i == tsr_pkg::CMD_RD);
  end
  // ****************************************
  // link domain
  // ****************************************
  busy_take_a: assert property (@(posedge link_clk_i) disable iff (!resetn_i)
    lnk_cmd_valid_i && !lnk_busy_o |-> ##[1:2] lnk_busy_o) else $error("busy missing");
  busy_span_a: assert property (@(posedge link_clk_i) disable iff (!resetn_i)
    $rose(lnk_busy_o) |-> ##[3:15] !lnk_busy_o) else $error("busy too long");
  rvalid_end_a: assert property (@(posedge link_clk_i) disable iff (!resetn_i)
    lnk_rvalid_o |-> !lnk_busy_o && $past(lnk_busy_o)) else $error("rvalid off busy end");
  rvalid_pulse_a: assert property (@(posedge link_clk_i) disable iff (!resetn_i)
    lnk_rvalid_o |=> !lnk_rvalid_o) else $error("rvalid too wide");
  rvalid_rd_a: assert property (@(posedge link_clk_i) disable iff (!resetn_i)
    lnk_rvalid_o |-> rd_ff) else $error("rvalid without read");
  rdata_hold_a: assert property (@(posedge link_clk_i) disable iff (!resetn_i)
    $changed(lnk_rdata_o) |-> lnk_rvalid_o) else $error("rdata moved");
  // ****************************************
  // core domain
  // ****************************************
  alert_rst_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    !$past(resetn_i) |-> alert_o) else $error("alert active after reset");
  conv_boot_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    !$past(resetn_i) |-> ##[1:3] conv_start_o) else $error("no boot conversion");
  conv_pulse_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    conv_start_o |=> !conv_start_o) else $error("start too wide");
endmodule // tsr_top_asserts

bind tsr_top tsr_top_asserts u_chk (.*);
